//--- logic/jfd_delay.sv
// Flagging-delay down-counter for one diagnostic definition.
// Assumes the fault level is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module jfd_delay #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic fault,
   input wire logic [W-1:0] delay,
   output logic expired
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } jfd_dly_st_t;
   jfd_dly_st_t s_q, s_d;

   // Reload while fault absent; count down while present, so a fault
   // that drops out early restarts the wait.
   always_comb begin
      s_d = s_q;
      if (!fault) begin
         s_d.cnt = delay;
         s_d.done = 1'b0;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end else begin
         s_d.done = 1'b1;
      end
   end

   // Register update.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign expired = s_q.done && fault;
endmodule // jfd_delay
`default_nettype wire

//--- logic/jfd_diag.sv
// Fault diagnostics top: definitions, trouble code states, message
// requests. Assumes an outside CAN/transport engine takes MSG requests
// and that REQ inputs come from decoded network requests.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module jfd_diag #(
   parameter int NDEF = 16,
   parameter int HOLDOFF = jfd_pkg::HOLDOFF_CYC,
   parameter int DW = 16
) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [DW-1:0] SUPPLY_VAL,
   input wire logic [DW-1:0] TEMP_VAL,
   input wire logic TIMEOUT_VAL,
   input wire logic [DW-1:0] OUTCUR_VAL,
   input wire logic REQ_DM2,
   input wire logic REQ_DM3,
   input wire logic REQ_DM11,
   output logic MSG_REQ,
   output logic [1:0] MSG_KIND,
   output logic [7:0] MSG_LAMP,
   output logic [NDEF-1:0] MSG_SET,
   input wire logic MSG_ACK,
   output logic [NDEF-1:0] OUT_FAULT,
   output logic OUTPUTS_OFF
);
   // Only the full and the reduced variant are served.
   if (NDEF != 16 && NDEF != 12) begin : g_bad_ndef
      $error("NDEF must be 16 or 12");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [NDEF-1:0][31:0] cfg;
      logic [NDEF-1:0][3:0][DW-1:0] thr;
      logic [NDEF-1:0][jfd_pkg::SPN_W-1:0] spn;
      logic [NDEF-1:0][15:0] dly;
      logic [NDEF-1:0][jfd_pkg::OC_W-1:0] oc;
      logic [NDEF-1:0] act;
      logic [NDEF-1:0] prev;
      logic [NDEF-1:0] flag_q;
      logic [4:0] ctrl;
      logic [31:0] hold;
      logic pend;
      logic req;
      logic [1:0] kind;
      logic [7:0] lamp;
      logic [NDEF-1:0] set;
      logic [31:0] rdata;
   } jfd_st_t;
   jfd_st_t s_q, s_d;

   // ----------------------------------------
   // Fault detection per definition
   // ----------------------------------------
   logic [NDEF-1:0] fault, expired, supply_f, temp_f;

   // Pick a definition's monitored value from its source field.
   function automatic logic [DW-1:0] pick(input logic [1:0] src);
      unique case (src)
         jfd_pkg::SRC_SUPPLY: pick = SUPPLY_VAL;
         jfd_pkg::SRC_TEMP: pick = TEMP_VAL;
         jfd_pkg::SRC_TIMEOUT: pick = {{(DW-1){1'b0}}, TIMEOUT_VAL};
         jfd_pkg::SRC_OUTCUR: pick = OUTCUR_VAL;
      endcase
   endfunction

   genvar g;
   generate
      for (g = 0; g < NDEF; g++) begin : g_def
         logic [DW-1:0] v;
         logic [1:0] ty, sr;
         assign sr = s_q.cfg[g][jfd_pkg::CFG_SRC +: 2];
         assign ty = s_q.cfg[g][jfd_pkg::CFG_TYPE +: 2];
         assign v = pick(sr);
         // Each comparison kind.
         always_comb begin
            unique case (jfd_pkg::jfd_ftype_t'(ty))
               // Flag outside the low/high band only.
               jfd_pkg::FT_MINMAX: fault[g] = v < s_q.thr[g][0] ||
                  v > s_q.thr[g][1];
               // Flag at or above one threshold.
               jfd_pkg::FT_ABS: fault[g] = v >= s_q.thr[g][0];
               // Fixed thresholds: nonzero is faulty.
               jfd_pkg::FT_STATE: fault[g] = v != '0;
               // Two outer and two inner limits.
               jfd_pkg::FT_DBL: fault[g] = v < s_q.thr[g][0] ||
                  v < s_q.thr[g][1] || v > s_q.thr[g][2] ||
                  v > s_q.thr[g][3];
            endcase
         end
         jfd_delay #(.W(16)) u_dly (
            .clk(MCLK),
            .rst(SYS_RST),
            .fault(fault[g]),
            .delay(s_q.dly[g]),
            .expired(expired[g])
         );
         // Internal flags by source.
         assign supply_f[g] = s_q.flag_q[g] && sr == jfd_pkg::SRC_SUPPLY;
         assign temp_f[g] = s_q.flag_q[g] && sr == jfd_pkg::SRC_TEMP;
         assign OUT_FAULT[g] = s_q.flag_q[g] && sr == jfd_pkg::SRC_OUTCUR;
      end
   endgenerate

   // Outputs off on supply or temperature fault when enabled.
   assign OUTPUTS_OFF = (|supply_f && s_q.ctrl[jfd_pkg::CTRL_PWR_SD]) ||
      (|temp_f && s_q.ctrl[jfd_pkg::CTRL_TMP_SD]);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [3:0] di;
   logic [2:0] dr;
   logic insel;
   logic [NDEF-1:0] rep, newly;
   logic [7:0] lamp;
   logic [4:0] nact;
   logic was_rep; // Some code was reported before this edge.
   logic dm2, dm3, dm11;

   always_comb begin
      s_d = s_q;
      di = 4'(ADDR[6:3] - 4'h2);
      dr = ADDR[2:0];
      insel = ADDR >= jfd_pkg::DEF_BASE &&
         32'(di) < NDEF && ADDR[7] == 1'b0;
      dm2 = REQ_DM2 || (WR && ADDR == jfd_pkg::REG_CTRL &&
         WDATA[jfd_pkg::CTRL_DM2]);
      dm3 = REQ_DM3 || (WR && ADDR == jfd_pkg::REG_CTRL &&
         WDATA[jfd_pkg::CTRL_DM3]);
      dm11 = REQ_DM11 || (WR && ADDR == jfd_pkg::REG_CTRL &&
         WDATA[jfd_pkg::CTRL_DM11]);
      newly = '0;
      // Fault flags follow the delayed detector.
      s_d.flag_q = expired;
      for (int i = 0; i < NDEF; i++) begin
         // Rising flag: active, count up, generation enabled.
         if (expired[i] && !s_q.flag_q[i] && s_q.cfg[i][jfd_pkg::CFG_GEN]) begin
            if (!s_q.act[i]) begin
               newly[i] = 1'b1;
            end
            s_d.act[i] = 1'b1;
            s_d.prev[i] = 1'b0;
            if (s_q.oc[i] != '1) begin
               s_d.oc[i] = s_q.oc[i] + 1'b1;
            end
         end else if (!expired[i] && s_q.act[i] &&
            !s_q.cfg[i][jfd_pkg::CFG_LATCH]) begin
            // Condition gone: previously active.
            s_d.act[i] = 1'b0;
            s_d.prev[i] = 1'b1;
         end
      end
      // Clears only on request; latched codes wait for DM11.
      if (dm11) begin
         for (int i = 0; i < NDEF; i++) begin
            if (!expired[i]) begin
               s_d.act[i] = 1'b0;
            end
         end
      end
      if (dm3) begin
         s_d.prev = '0;
         for (int i = 0; i < NDEF; i++) begin
            if (!s_q.act[i]) begin
               s_d.oc[i] = '0;
            end
         end
      end
      // Register writes; an SPN change zeroes the count even if it rose in the same cycle.
      if (WR && ADDR == jfd_pkg::REG_CTRL) begin
         s_d.ctrl = {2'h0, 1'b0, WDATA[1:0]};
      end
      if (WR && insel) begin
         unique case (dr)
            jfd_pkg::DR_CFG: s_d.cfg[di] = WDATA;
            jfd_pkg::DR_THR0: s_d.thr[di][0] = WDATA[DW-1:0];
            jfd_pkg::DR_THR1: s_d.thr[di][1] = WDATA[DW-1:0];
            jfd_pkg::DR_THR2: s_d.thr[di][2] = WDATA[DW-1:0];
            jfd_pkg::DR_THR3: s_d.thr[di][3] = WDATA[DW-1:0];
            jfd_pkg::DR_SPN: begin
               s_d.spn[di] = WDATA[jfd_pkg::SPN_W-1:0];
               if (WDATA[jfd_pkg::SPN_W-1:0] != s_q.spn[di]) begin
                  s_d.oc[di] = '0;
               end
            end
            jfd_pkg::DR_DLY: s_d.dly[di] = WDATA[15:0];
            jfd_pkg::DR_OC: ;
         endcase
      end
      // Reported set excludes zero SPN.
      lamp = 8'h00;
      nact = '0;
      was_rep = 1'b0;
      for (int i = 0; i < NDEF; i++) begin
         // Zero-SPN codes never count, so they cannot trigger messages.
         if (s_q.act[i] && s_q.spn[i] != '0) begin
            was_rep = 1'b1;
         end
         rep[i] = s_d.act[i] && s_q.spn[i] != '0;
         if (rep[i]) begin
            nact = nact + 1'b1;
            lamp[2 * s_q.cfg[i][jfd_pkg::CFG_LAMP +: 2] +: 2] = 2'h1;
         end
      end
      // Power-up hold-off counter.
      if (s_q.hold != '0) begin
         s_d.hold = s_q.hold - 1'b1;
      end
      // Edges to nothing-active or new code ask for a message.
      if (|(newly & rep) || (was_rep && nact == '0)) begin
         s_d.pend = 1'b1;
      end
      if (s_q.req && MSG_ACK) begin
         s_d.req = 1'b0;
      end else if (!s_q.req && s_q.hold == '0 && s_q.pend) begin
         s_d.req = 1'b1;
         s_d.pend = 1'b0;
         s_d.set = rep;
         s_d.lamp = lamp;
         // No codes, one, or several by transport.
         s_d.kind = nact == '0 ? jfd_pkg::MSG_NOFAULT :
            nact == 5'h1 ? jfd_pkg::MSG_SINGLE : jfd_pkg::MSG_MULTI;
      end else if (!s_q.req && dm2) begin
         s_d.req = 1'b1;
         s_d.set = s_q.prev;
         s_d.lamp = 8'h00;
         s_d.kind = jfd_pkg::MSG_PREV;
      end
      // Read data, one cycle after the strobe.
      s_d.rdata = 32'h0;
      if (RD) begin
         if (ADDR == jfd_pkg::REG_CTRL) begin
            s_d.rdata = 32'(s_q.ctrl);
         end else if (ADDR == jfd_pkg::REG_STAT) begin
            s_d.rdata = {30'h0, OUTPUTS_OFF, s_q.hold == '0};
         end else if (ADDR == jfd_pkg::REG_ACTIVE) begin
            s_d.rdata = 32'(s_q.act);
         end else if (ADDR == jfd_pkg::REG_PREV) begin
            s_d.rdata = 32'(s_q.prev);
         end else if (insel) begin
            unique case (dr)
               jfd_pkg::DR_CFG: s_d.rdata = s_q.cfg[di];
               jfd_pkg::DR_THR0: s_d.rdata = 32'(s_q.thr[di][0]);
               jfd_pkg::DR_THR1: s_d.rdata = 32'(s_q.thr[di][1]);
               jfd_pkg::DR_THR2: s_d.rdata = 32'(s_q.thr[di][2]);
               jfd_pkg::DR_THR3: s_d.rdata = 32'(s_q.thr[di][3]);
               // Code word: SPN, FMI, CM held at zero, count.
               jfd_pkg::DR_SPN: s_d.rdata = 32'(s_q.spn[di]);
               jfd_pkg::DR_DLY: s_d.rdata = 32'(s_q.dly[di]);
               jfd_pkg::DR_OC: s_d.rdata = {s_q.spn[di][7:0],
                  s_q.spn[di][15:8], s_q.spn[di][18:16],
                  s_q.cfg[di][jfd_pkg::CFG_FMI +: jfd_pkg::FMI_W],
                  jfd_pkg::CM_VALUE, s_q.oc[di]};
            endcase
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Reset loads the default sources of definitions 0-2. The count is
   // kept in flops here; a real part backs it with non-volatile memory.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_q <= '0;
         s_q.cfg[1][jfd_pkg::CFG_SRC +: 2] <= jfd_pkg::SRC_TEMP;
         s_q.cfg[2][jfd_pkg::CFG_SRC +: 2] <= jfd_pkg::SRC_TIMEOUT;
         s_q.cfg[2][jfd_pkg::CFG_TYPE +: 2] <= 2'h2;
         s_q.hold <= 32'(HOLDOFF);
         // A no-fault message waits for the end of the hold-off.
         s_q.pend <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA = s_q.rdata;
   assign MSG_REQ = s_q.req;
   assign MSG_KIND = s_q.kind;
   assign MSG_LAMP = s_q.lamp;
   assign MSG_SET = s_q.set;
endmodule // jfd_diag
`default_nettype wire

//--- logic/jfd_pkg.sv
// Constants shared by the fault diagnostics block, its checker and its bench.
// Assumes a single 50 MHz clock and a plain register port.
`default_nettype none
package jfd_pkg;
   // Clock rate and power-up hold-off.
   localparam int CLK_HZ = 50000000;
   localparam int HOLDOFF_S = 5;
   localparam int HOLDOFF_CYC = HOLDOFF_S * CLK_HZ;
   // Fault types.
   typedef enum logic [1:0] {
      FT_MINMAX = 2'h0,
      FT_ABS = 2'h1,
      FT_STATE = 2'h2,
      FT_DBL = 2'h3
   } jfd_ftype_t;
   // Lamp selectors: which two-bit field of the first message byte a code sets.
   localparam logic [1:0] LAMP_PROTECT = 2'h0;
   localparam logic [1:0] LAMP_AMBER = 2'h1;
   localparam logic [1:0] LAMP_RED = 2'h2;
   localparam logic [1:0] LAMP_MALF = 2'h3;
   // Trouble code layout.
   localparam int SPN_W = 19;
   localparam int FMI_W = 5;
   localparam int OC_W = 7;
   localparam logic CM_VALUE = 1'b0;
   // Monitored source codes of the config word; reset gives definitions 0-2 the first three.
   localparam logic [1:0] SRC_SUPPLY = 2'h0;
   localparam logic [1:0] SRC_TEMP = 2'h1;
   localparam logic [1:0] SRC_TIMEOUT = 2'h2;
   localparam logic [1:0] SRC_OUTCUR = 2'h3;
   // Register offsets, word addressed. Per definition d and slot s:
   // base = DEF_BASE + d*DEF_STRIDE, for d from 0 to 13 only.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h01;
   localparam logic [7:0] REG_ACTIVE = 8'h02;
   localparam logic [7:0] REG_PREV = 8'h03;
   localparam logic [7:0] DEF_BASE = 8'h10;
   localparam int DEF_STRIDE = 8;
   localparam logic [2:0] DR_CFG = 3'h0;
   localparam logic [2:0] DR_THR0 = 3'h1;
   localparam logic [2:0] DR_THR1 = 3'h2;
   localparam logic [2:0] DR_THR2 = 3'h3;
   localparam logic [2:0] DR_THR3 = 3'h4;
   localparam logic [2:0] DR_SPN = 3'h5;
   localparam logic [2:0] DR_DLY = 3'h6;
   localparam logic [2:0] DR_OC = 3'h7;
   // Control bits of REG_CTRL.
   localparam int CTRL_PWR_SD = 0;
   localparam int CTRL_TMP_SD = 1;
   localparam int CTRL_DM11 = 2;
   localparam int CTRL_DM3 = 3;
   localparam int CTRL_DM2 = 4;
   // Fields of the per-definition config word.
   localparam int CFG_TYPE = 0;
   localparam int CFG_SRC = 2;
   localparam int CFG_LAMP = 4;
   localparam int CFG_GEN = 6;
   localparam int CFG_LATCH = 7;
   localparam int CFG_FMI = 8;
   localparam int CFG_OUT = 13;
   // Message kinds on the transmit request port.
   typedef enum logic [1:0] {
      MSG_NOFAULT = 2'h0,
      MSG_SINGLE = 2'h1,
      MSG_MULTI = 2'h2,
      MSG_PREV = 2'h3
   } jfd_msg_t;
endpackage
`default_nettype wire

//--- sim/jfd_diag_monitor.sv
// Checker for the diagnostics top; it sees only the top's ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module jfd_diag_monitor #(
   parameter int NDEF = 16,
   parameter int HOLDOFF = 100
) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic REQ_DM2,
   input wire logic MSG_REQ,
   input wire logic [1:0] MSG_KIND,
   input wire logic [7:0] MSG_LAMP,
   input wire logic [NDEF-1:0] MSG_SET,
   input wire logic MSG_ACK,
   input wire logic OUTPUTS_OFF
);
   // ------------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------------
   int hold_q; // Cycles since reset, saturating at the hold-off.
   logic [1:0] sd_q; // Shutdown enables as last written.
   logic prev_q; // A list request was taken and not yet answered.

   // Mirrors of what the checks need; a list request is only taken idle.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hold_q <= 0;
         sd_q <= 2'h0;
         prev_q <= 1'b0;
      end else begin
         if (hold_q < HOLDOFF) begin
            hold_q <= hold_q + 1;
         end
         if (WR && ADDR == jfd_pkg::REG_CTRL) begin
            sd_q <= WDATA[1:0];
         end
         if (REQ_DM2 && !MSG_REQ) begin
            prev_q <= 1'b1;
         end else if (MSG_ACK && MSG_KIND == jfd_pkg::MSG_PREV) begin
            prev_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside the answer cycle");
   a_hold_quiet: assert property (hold_q < HOLDOFF - 1 |-> !MSG_REQ)
      else $error("message during power-up hold-off");
   a_msg_stands: assert property (MSG_REQ && !MSG_ACK |=> MSG_REQ &&
      $stable(MSG_KIND) && $stable(MSG_SET) && $stable(MSG_LAMP))
      else $error("message changed before acknowledge");
   a_nofault_empty: assert property (MSG_REQ &&
      MSG_KIND == jfd_pkg::MSG_NOFAULT |-> MSG_SET == '0)
      else $error("no-fault message lists codes");
   a_single_one: assert property (MSG_REQ &&
      MSG_KIND == jfd_pkg::MSG_SINGLE |-> $onehot(MSG_SET))
      else $error("single message without exactly one code");
   a_multi_many: assert property (MSG_REQ &&
      MSG_KIND == jfd_pkg::MSG_MULTI |-> $countones(MSG_SET) > 1)
      else $error("multipacket message with under two codes");
   a_lamp_code: assert property (MSG_REQ |-> (MSG_LAMP & 8'haa) == 8'h0)
      else $error("lamp field holds an unused code");
   a_prev_asked: assert property (MSG_REQ &&
      MSG_KIND == jfd_pkg::MSG_PREV |-> prev_q)
      else $error("previous-code list sent unasked");
   a_shut_gate: assert property (sd_q == 2'h0 |-> !OUTPUTS_OFF)
      else $error("outputs off with shutdown disabled");

   c_single: cover property (MSG_REQ && MSG_KIND == jfd_pkg::MSG_SINGLE);
   c_multi: cover property (MSG_REQ && MSG_KIND == jfd_pkg::MSG_MULTI);
   c_prev: cover property (MSG_REQ && MSG_KIND == jfd_pkg::MSG_PREV);
endmodule // jfd_diag_monitor

bind jfd_diag jfd_diag_monitor #(.NDEF(NDEF), .HOLDOFF(HOLDOFF)) u_mon (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .REQ_DM2(REQ_DM2), .MSG_REQ(MSG_REQ),
   .MSG_KIND(MSG_KIND), .MSG_LAMP(MSG_LAMP), .MSG_SET(MSG_SET),
   .MSG_ACK(MSG_ACK), .OUTPUTS_OFF(OUTPUTS_OFF));
`default_nettype wire

//--- sim/jfd_diag_tb.sv
// Self-checking bench for the diagnostics top with a far node model.
// Assumes a hold-off of 100 cycles and delays counted in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module jfd_diag_tb;
   logic MCLK, SYS_RST, WR, RD, TIMEOUT_VAL, MSG_REQ, MSG_ACK, OUTPUTS_OFF;
   logic REQ_DM2, REQ_DM3, REQ_DM11;
   logic [7:0] ADDR, MSG_LAMP, got_lamp;
   logic [31:0] WDATA, RDATA, w0, w1;
   logic [15:0] SUPPLY_VAL, TEMP_VAL, OUTCUR_VAL, MSG_SET, OUT_FAULT, got_set;
   logic [1:0] MSG_KIND;
   logic [3:0] p_dly; // Far node answer wait; slow makes requests stand.
   int fails, samples_checked, cyc, t;

   jfd_diag #(.NDEF(16), .HOLDOFF(100), .DW(16)) u_dut (.MCLK(MCLK),
      .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SUPPLY_VAL(SUPPLY_VAL), .TEMP_VAL(TEMP_VAL),
      .TIMEOUT_VAL(TIMEOUT_VAL), .OUTCUR_VAL(OUTCUR_VAL), .REQ_DM2(REQ_DM2),
      .REQ_DM3(REQ_DM3), .REQ_DM11(REQ_DM11), .MSG_REQ(MSG_REQ),
      .MSG_KIND(MSG_KIND), .MSG_LAMP(MSG_LAMP), .MSG_SET(MSG_SET),
      .MSG_ACK(MSG_ACK), .OUT_FAULT(OUT_FAULT), .OUTPUTS_OFF(OUTPUTS_OFF));
   jfd_node u_node (.clk(MCLK), .rst(SYS_RST), .msg_req(MSG_REQ),
      .dly(p_dly), .msg_ack(MSG_ACK));

   // ------------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // ------------------------------------------------------------------
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end

   // The run needs about 450 cycles; the ceiling leaves ample room.
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      @(negedge MCLK);
      d = RDATA;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      cmp(v & m, e);
   endtask

   function automatic logic [7:0] da(input int d, input logic [2:0] r);
      return jfd_pkg::DEF_BASE + 8'(d * jfd_pkg::DEF_STRIDE) + {5'h0, r};
   endfunction

   function automatic logic [31:0] cf(input logic [1:0] ty, src, lamp,
                                      input logic gen, lat);
      return {19'h0, 5'h3, lat, gen, lamp, src, ty};
   endfunction

   // Thresholds, number and delay go in before the enabling config word.
   task automatic setdef(input int d, input logic [31:0] c, t0, t1, s, dl);
      wr(da(d, jfd_pkg::DR_THR0), t0);
      wr(da(d, jfd_pkg::DR_THR1), t1);
      wr(da(d, jfd_pkg::DR_SPN), s);
      wr(da(d, jfd_pkg::DR_DLY), dl);
      wr(da(d, jfd_pkg::DR_CFG), c);
   endtask

   // Waits for an acknowledged message of one kind; n is cycles waited.
   task automatic wmsg(input logic [1:0] k, output int n);
      n = 0;
      do begin
         @(negedge MCLK);
         n++;
      end while (!(MSG_ACK === 1'b1 && MSG_KIND === k) && n < 400);
      cmp(32'(n < 400), 32'h1);
      got_set = MSG_SET;
      got_lamp = MSG_LAMP;
   endtask

   // Counts code-carrying messages over a window that should be silent.
   task automatic quiet(input int c);
      int hits;
      hits = 0;
      repeat (c) begin
         @(negedge MCLK);
         if (MSG_ACK === 1'b1 && MSG_KIND !== jfd_pkg::MSG_NOFAULT) hits++;
      end
      cmp(32'(hits), 32'h0);
   endtask

   task automatic req(input logic [2:0] w);
      @(posedge MCLK);
      {REQ_DM11, REQ_DM3, REQ_DM2} <= w;
      @(posedge MCLK);
      {REQ_DM11, REQ_DM3, REQ_DM2} <= 3'h0;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      fails = 0;
      samples_checked = 0;
      cyc = 0;
      SYS_RST = 1'b1;
      {WR, RD, REQ_DM2, REQ_DM3, REQ_DM11, TIMEOUT_VAL} = 6'h0;
      ADDR = 8'h0;
      WDATA = 32'h0;
      {SUPPLY_VAL, TEMP_VAL, OUTCUR_VAL} = 48'h0;
      p_dly = 4'h0;
      repeat (10) @(posedge MCLK);
      SYS_RST <= 1'b0;
      rchk(jfd_pkg::REG_STAT, 32'h1, 32'h0);
      rchk(8'h08, 32'hffffffff, 32'h0);
      for (int d = 0; d < 3; d++) rchk(da(d, 3'h0), 32'hc, 32'(d) << 2);
      wmsg(jfd_pkg::MSG_NOFAULT, t);
      cmp(32'(got_set), 32'h0);
      rchk(jfd_pkg::REG_STAT, 32'h1, 32'h1);
      setdef(3, cf(jfd_pkg::FT_ABS, jfd_pkg::SRC_SUPPLY, jfd_pkg::LAMP_RED,
         1'b1, 1'b0), 32'h100, 32'h0, 32'h123, 32'd20);
      rd(da(3, jfd_pkg::DR_OC), w0);
      @(posedge MCLK);
      SUPPLY_VAL <= 16'h100;
      repeat (8) @(posedge MCLK);
      SUPPLY_VAL <= 16'h0ff;
      quiet(40);
      @(posedge MCLK);
      SUPPLY_VAL <= 16'h100;
      wmsg(jfd_pkg::MSG_SINGLE, t);
      cmp(32'(t >= 20 && t <= 30), 32'h1);
      cmp(32'(got_set), 32'h8);
      cmp(32'(got_lamp), 32'h10);
      rchk(jfd_pkg::REG_ACTIVE, 32'hffff, 32'h8);
      rd(da(3, jfd_pkg::DR_OC), w1);
      cmp(32'(w1 !== w0), 32'h1);
      p_dly <= 4'h7;
      setdef(4, cf(jfd_pkg::FT_STATE, jfd_pkg::SRC_TIMEOUT,
         jfd_pkg::LAMP_AMBER, 1'b1, 1'b1), 32'h0, 32'h0, 32'h200, 32'd5);
      @(posedge MCLK);
      TIMEOUT_VAL <= 1'b1;
      wmsg(jfd_pkg::MSG_MULTI, t);
      cmp(32'(got_set), 32'h18);
      cmp(32'(got_lamp), 32'h14);
      @(posedge MCLK);
      TIMEOUT_VAL <= 1'b0;
      SUPPLY_VAL <= 16'h0;
      repeat (40) @(posedge MCLK);
      rchk(jfd_pkg::REG_ACTIVE, 32'hffff, 32'h10);
      rchk(jfd_pkg::REG_PREV, 32'h8, 32'h8);
      wr(da(3, jfd_pkg::DR_SPN), 32'h124);
      wr(da(3, jfd_pkg::DR_SPN), 32'h123);
      rchk(da(3, jfd_pkg::DR_OC), 32'hffffffff, w0);
      req(3'h4);
      wmsg(jfd_pkg::MSG_NOFAULT, t);
      rchk(jfd_pkg::REG_ACTIVE, 32'hffff, 32'h0);
      req(3'h1);
      wmsg(jfd_pkg::MSG_PREV, t);
      cmp(32'(got_set[3]), 32'h1);
      req(3'h2);
      rchk(jfd_pkg::REG_PREV, 32'hffff, 32'h0);
      setdef(5, cf(jfd_pkg::FT_ABS, jfd_pkg::SRC_TEMP, 2'h1, 1'b1, 1'b0),
         32'h10, 32'h0, 32'h0, 32'd3);
      setdef(6, cf(jfd_pkg::FT_ABS, jfd_pkg::SRC_OUTCUR, 2'h1, 1'b0, 1'b0),
         32'h50, 32'h0, 32'h300, 32'd3);
      setdef(7, cf(jfd_pkg::FT_MINMAX, jfd_pkg::SRC_OUTCUR, 2'h1, 1'b1,
         1'b0), 32'h10, 32'h200, 32'h301, 32'd3);
      setdef(8, cf(jfd_pkg::FT_DBL, jfd_pkg::SRC_SUPPLY, 2'h1, 1'b0, 1'b0),
         32'h10, 32'h20, 32'h302, 32'd3);
      rchk(da(8, jfd_pkg::DR_CFG), 32'h3, 32'h3);
      @(posedge MCLK);
      TEMP_VAL <= 16'h20;
      OUTCUR_VAL <= 16'h60;
      quiet(40);
      cmp(32'(OUT_FAULT & 16'h00c0), 32'h40);
      @(posedge MCLK);
      SUPPLY_VAL <= 16'h100;
      repeat (40) @(posedge MCLK);
      wr(jfd_pkg::REG_CTRL, 32'h1);
      repeat (3) @(negedge MCLK);
      cmp(32'(OUTPUTS_OFF), 32'h1);
      test_done();
   end
endmodule // jfd_diag_tb
`default_nettype wire

//--- sim/jfd_node.sv
// Model of a far network node that takes the block's message requests.
// Assumes requests stand until acknowledged and one clock for both sides.
`timescale 1ns/1ps
`default_nettype none
module jfd_node (
   input wire logic clk,
   input wire logic rst,
   input wire logic msg_req,
   input wire logic [3:0] dly,
   output logic msg_ack
);
   // ------------------------------------------------------------------
   // Acknowledge after a settable wait
   // ------------------------------------------------------------------
   logic [3:0] cnt_q; // Cycles the current request has waited.

   // A busy bus is modelled by a longer wait; the pulse is one cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         msg_ack <= 1'b0;
      end else if (msg_ack) begin
         msg_ack <= 1'b0;
         cnt_q <= 4'h0;
      end else if (msg_req) begin
         if (cnt_q >= dly) begin
            msg_ack <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule // jfd_node
`default_nettype wire
